//--- rtl/lbp_pkg.sv
// Package for the four-channel LED blink PWM block.
// Assumes a single 125 MHz clock; settings arrive as plain ports.
package lbp_pkg;

    // ------------------------------------------------------------
    // Clock and period timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ          = 125000000;
    // Each period is cut into 16 duty slots; slot length per rate in cycles
    localparam int     RATE_0P25_MHZ   = 250;      // 0.25 Hz in mHz
    localparam int     RATE_0P5_MHZ    = 500;
    localparam int     RATE_1_MHZ      = 1000;
    localparam int     RATE_2_MHZ      = 2000;
    localparam int     RATE_128_MHZ    = 128000;
    localparam int     RATE_256_MHZ    = 256000;
    localparam int     SLOTS           = 16;
    localparam int     SLOT_W          = 32;
    localparam logic [SLOT_W-1:0] SLOT_0P25 = SLOT_W'((CLK_HZ * 1000) / (RATE_0P25_MHZ * SLOTS));
    localparam logic [SLOT_W-1:0] SLOT_0P5  = SLOT_W'((CLK_HZ * 1000) / (RATE_0P5_MHZ * SLOTS));
    localparam logic [SLOT_W-1:0] SLOT_1    = SLOT_W'((CLK_HZ * 1000) / (RATE_1_MHZ * SLOTS));
    localparam logic [SLOT_W-1:0] SLOT_2    = SLOT_W'((CLK_HZ * 1000) / (RATE_2_MHZ * SLOTS));
    localparam logic [SLOT_W-1:0] SLOT_128  = SLOT_W'((CLK_HZ * 1000) / (RATE_128_MHZ * SLOTS));
    localparam logic [SLOT_W-1:0] SLOT_256  = SLOT_W'((CLK_HZ * 1000) / (RATE_256_MHZ * SLOTS));

    // ------------------------------------------------------------
    // Field layout and codes
    // ------------------------------------------------------------
    localparam int         RATE_W    = 3;
    localparam int         DUTY_W    = 4;
    localparam int         NCH       = 4;
    localparam logic [2:0] RATE_0P25 = 3'h0;
    localparam logic [2:0] RATE_0P5  = 3'h1;
    localparam logic [2:0] RATE_1    = 3'h2;
    localparam logic [2:0] RATE_2    = 3'h3;
    localparam logic [2:0] RATE_128  = 3'h4;
    localparam logic [2:0] RATE_256  = 3'h5;

    // Reset defaults of the channel settings
    localparam logic [2:0] RST_RATE_FIRST = 3'h5;  // 256 Hz
    localparam logic [3:0] RST_DUTY_FIRST = 4'h7;  // 50 %
    localparam logic [2:0] RST_RATE_OTHER = 3'h0;  // 0.25 Hz
    localparam logic [3:0] RST_DUTY_OTHER = 4'h0;  // 6.25 %

    // Write strobe with the setting it carries
    typedef struct packed {
        logic              wr;
        logic              enable;
        logic [RATE_W-1:0] blink_rate_select;
        logic [DUTY_W-1:0] duty;
    } lbp_cfg_t;

    // Per-channel state
    typedef struct packed {
        logic              enable;
        logic [RATE_W-1:0] blink_rate_select;
        logic [DUTY_W-1:0] duty;
        logic [SLOT_W-1:0] slot_cnt;
        logic [3:0]        slot;
        logic              led;
    } lbp_ch_t;

    typedef struct packed {
        lbp_ch_t [NCH-1:0] ch;
    } lbp_state_t;

endpackage : lbp_pkg

//--- rtl/lbp_led_pwm.sv
// Four independent low-rate PWM LED outputs.
// Assumes settings come from a serial control slave on the same clock.
`timescale 1ns/10ps

module lbp_led_pwm
    import lbp_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire lbp_cfg_t [3:0]  cfg,
    output logic                 led_channel_first,
    output logic                 led_channel_second,
    output logic                 led_channel_third,
    output logic                 led_channel_fourth,
    output logic [3:0]           ch_enabled,
    output logic [3:0]           ch_rate_first,
    output logic [3:0]           ch_duty_first
);

    // ------------------------------------------------------------
    // Rate decode
    // ------------------------------------------------------------
    function automatic logic [SLOT_W-1:0] slot_len(input logic [RATE_W-1:0] code);
        logic [SLOT_W-1:0] len;
        len = SLOT_0P25;
        unique case (code)
            RATE_0P25: len = SLOT_0P25;
            RATE_0P5:  len = SLOT_0P5;
            RATE_1:    len = SLOT_1;
            RATE_2:    len = SLOT_2;
            RATE_128:  len = SLOT_128;
            RATE_256:  len = SLOT_256;
            default:   len = SLOT_0P25;
        endcase
        return len;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lbp_state_t st_r;
    lbp_state_t st_nxt;

    // Next state: per-channel settings and period counters
    always_comb begin
        st_nxt = st_r;
        for (int i = 0; i < NCH; i++) begin
            // A write restarts the period so the new rate takes a clean edge
            if (cfg[i].wr) begin
                st_nxt.ch[i].enable            = cfg[i].enable;
                st_nxt.ch[i].blink_rate_select = cfg[i].blink_rate_select;
                st_nxt.ch[i].duty              = cfg[i].duty;
                st_nxt.ch[i].slot_cnt          = '0;
                st_nxt.ch[i].slot              = 4'h0;
            end else if (st_r.ch[i].enable) begin
                if (st_r.ch[i].slot_cnt >= slot_len(st_r.ch[i].blink_rate_select) - SLOT_W'(1)) begin
                    st_nxt.ch[i].slot_cnt = '0;
                    st_nxt.ch[i].slot     = st_r.ch[i].slot + 4'h1;      // Wraps every 16 slots
                end else begin
                    st_nxt.ch[i].slot_cnt = st_r.ch[i].slot_cnt + SLOT_W'(1);
                end
            end else begin
                st_nxt.ch[i].slot_cnt = '0;
                st_nxt.ch[i].slot     = 4'h0;
            end
            // High for slots 0..n, i.e. (n+1)/16; n=15 never goes low
            st_nxt.ch[i].led = st_nxt.ch[i].enable &&
                               (st_nxt.ch[i].slot <= st_nxt.ch[i].duty);
        end
    end

    // Register the state; channel 0 has its own defaults
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NCH; i++) begin
                st_r.ch[i].enable            <= 1'b0;
                st_r.ch[i].blink_rate_select <= (i == 0) ? RST_RATE_FIRST : RST_RATE_OTHER;
                st_r.ch[i].duty              <= (i == 0) ? RST_DUTY_FIRST : RST_DUTY_OTHER;
                st_r.ch[i].slot_cnt          <= '0;
                st_r.ch[i].slot              <= 4'h0;
                st_r.ch[i].led               <= 1'b0;
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign led_channel_first  = st_r.ch[0].led;
    assign led_channel_second = st_r.ch[1].led;
    assign led_channel_third  = st_r.ch[2].led;
    assign led_channel_fourth = st_r.ch[3].led;
    assign ch_rate_first      = {1'b0, st_r.ch[0].blink_rate_select};
    assign ch_duty_first      = st_r.ch[0].duty;

    // Status: which channels are enabled
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ch_enabled[i] = st_r.ch[i].enable;
        end
    end

endmodule // lbp_led_pwm

//--- tb/lbp_lamps.sv
// Lamp model: counts lit cycles of each pin.
// Sits on the four PWM pins, same clock.
`timescale 1ns/10ps
module lbp_lamps (
    input wire logic       clk,
    input wire logic [3:0] led,
    output int             lit [4]
);
    // Lit time is what the eye sees, so it is all we measure
    always @(posedge clk) for (int i = 0; i < 4; i++) lit[i] <= lit[i] + int'(led[i]);
endmodule // lbp_lamps

//--- tb/lbp_pwm_asserts.sv
// Port checker of the LED PWM block.
// Bound to lbp_led_pwm; one clock, async reset.
`timescale 1ns/10ps
module lbp_pwm_asserts
    import lbp_pkg::*;
(
    input wire logic           clk,
    input wire logic           rst_n,
    input wire lbp_cfg_t [3:0] cfg,
    input wire logic           led_channel_first,
    input wire logic           led_channel_second,
    input wire logic           led_channel_third,
    input wire logic           led_channel_fourth,
    input wire logic [3:0]     ch_enabled,
    input wire logic [3:0]     ch_rate_first,
    input wire logic [3:0]     ch_duty_first
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Write to the first channel
    sequence wr_s; cfg[0].wr; endsequence
    // Settings load on the write edge and are seen one cycle later
    off_dark_a: assert property (!ch_enabled[3] |-> !led_channel_fourth) else $error("lit off");
    en_load_a: assert property (wr_s |=> ch_enabled[0] == $past(cfg[0].enable)) else $error("enable");
    rate_load_a: assert property (wr_s |=> ch_rate_first == {1'b0, $past(cfg[0].blink_rate_select)})
        else $error("rate");
    rate_hold_a: assert property (!cfg[0].wr |=> $stable(ch_rate_first)) else $error("rate moved");
    duty_load_a: assert property (wr_s |=> ch_duty_first == $past(cfg[0].duty)) else $error("duty");
    slot_start_a: assert property (wr_s ##0 cfg[0].enable |=> led_channel_first) else $error("no start");
    full_duty_a: assert property (ch_enabled[0] && ch_duty_first == 4'hf |-> led_channel_first)
        else $error("full duty");
    rst_dflt_a: assert property ($rose(rst_n) |-> {ch_enabled, ch_rate_first, ch_duty_first} == 12'h057)
        else $error("defaults");
endmodule // lbp_pwm_asserts

bind lbp_led_pwm lbp_pwm_asserts chk (.*);

//--- tb/led_blink_pwm_quad_tb.sv
// Bench of lbp_led_pwm against a model of its settings.
// Needs lbp_pkg, the lamp model and the checker.
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("unexpected %0t mismatch", $time); end end
module led_blink_pwm_quad_tb;
    import lbp_pkg::*;
    logic           clk = 0;
    logic           rst_n = 0;
    lbp_cfg_t [3:0] cfg = '0;
    logic [3:0]     led, ch_enabled, ch_rate_first, ch_duty_first;
    int             err_total = 0, num_checks = 0, n, b1, b2, b3, lit [4];
    int             m_en [4] = '{0, 0, 0, 0}, m_rt = 5, m_du = 7;
    initial forever #4 clk = ~clk;
    lbp_led_pwm uut (.clk, .rst_n, .cfg, .led_channel_first(led[0]), .led_channel_second(led[1]),
        .led_channel_third(led[2]), .led_channel_fourth(led[3]), .ch_enabled, .ch_rate_first, .ch_duty_first);
    lbp_lamps lamps (.clk, .led, .lit);
    // One write; an enabled pin restarts lit at slot 0
    task automatic wr(int c, int e, int r, int d);
        @(negedge clk);
        cfg[c] = {1'b1, 1'(e), 3'(r), 4'(d)};
        m_en[c] = e;
        m_rt = (c == 0) ? r : m_rt;
        m_du = (c == 0) ? d : m_du;
        @(negedge clk);
        cfg[c].wr = 1'b0;
        `CHK(ch_enabled[c], 1'(m_en[c]))
        `CHK(led[c], 1'(m_en[c]))
        `CHK(ch_rate_first, 4'(m_rt))
        `CHK(ch_duty_first, 4'(m_du))
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Full periods are too long to run, so only the first lit stretch is timed
    initial begin
        void'($urandom(32'h5ba0));
        repeat (10) @(negedge clk);
        `CHK(led, 4'h0)
        `CHK(ch_enabled, 4'h0)
        `CHK({ch_rate_first, ch_duty_first}, 8'h57)
        rst_n = 1;
        for (n = 0; n < 32; n++) wr(n % 4, $urandom_range(1), n / 4, $urandom_range(15));
        wr(0, 1, 5, 15);
        wr(1, 1, 5, 1);
        b1 = lit[1];
        wr(3, 1, 5, 0);
        b3 = lit[3];
        // 128 Hz with duty code 0 lights for exactly one slot of that rate
        wr(2, 1, 4, 0);
        b2 = lit[2];
        for (n = 0; n < 70000 && (led[1] || led[2] || led[3]); n++) @(negedge clk);
        if (n == 70000) err_total++;
        `CHK(lit[1] - b1, 2 * (125000000 / 4096))
        `CHK(lit[3] - b3, 125000000 / 4096)
        `CHK(lit[2] - b2, 125000000 / 2048)
        `CHK(led[0], 1'b1)
        end_of_test();
    end
endmodule // led_blink_pwm_quad_tb
